// ### common/ucb_pkg.sv
// Purpose: Shared constants for the serial control and bit-rate block
// Assumes: 3-bit register address, 8-bit register data
// Notes: Bit positions index the 8-bit register words
package ucb_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [2:0] OFS_CONTROL_ONE = 3'h0;
  localparam logic [2:0] OFS_CONTROL_TWO = 3'h1;
  localparam logic [2:0] OFS_SINGLE_LINE = 3'h2;
  localparam logic [2:0] OFS_DATA_BUFFER = 3'h3;
  localparam logic [2:0] OFS_DIVISOR = 3'h4;
  localparam logic [2:0] OFS_STATUS = 3'h5;

  // ==========================================================
  // Control one fields
  localparam int BIT_MASTER_EN = 7;
  localparam int BIT_WORD_LEN = 6;
  localparam int BIT_RX_NINTH = 1;
  localparam int BIT_TX_NINTH = 0;

  // ==========================================================
  // Control two fields
  localparam int BIT_TX_EN = 7;
  localparam int BIT_RX_EN = 6;
  localparam int BIT_SPEED = 5;
  localparam int BIT_ADDR_DET = 4;
  localparam int BIT_WAKE_EN = 3;
  localparam int BIT_RX_IE = 2;
  localparam int BIT_IDLE_IE = 1;
  localparam int BIT_EMPTY_IE = 0;

  // ==========================================================
  // Single line and status fields
  localparam int BIT_SINGLE_LINE = 0;
  localparam int BIT_OVERRUN = 5;
  localparam int BIT_WAKE_PEND = 4;
  localparam int BIT_RX_READY = 2;
  localparam int BIT_TX_IDLE = 1;
  localparam int BIT_TX_EMPTY = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
  localparam logic [7:0] RST_CONTROL_TWO = 8'h00;
  localparam logic [7:0] RST_SINGLE_LINE = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DIVISOR = 8'h00;

  // ==========================================================
  // Prescaler terminal counts (periods 64 and 16)
  localparam logic [5:0] PRESCALE_LOW_LAST = 6'h3F;
  localparam logic [5:0] PRESCALE_HIGH_LAST = 6'h0F;

endpackage

// ### design/ucb_baud_gen.sv
// Purpose: Free-running bit-rate tick generator
// Assumes: clear high while the unit is disabled
// Notes: One tick every prescale*(N+1) clocks
`timescale 1ns/10ps
`default_nettype none
module ucb_baud_gen
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Control
  input wire logic clear,
  input wire logic speed_high,
  input wire logic [7:0] divisor,
  // Tick
  output logic tick
);

  logic [5:0] pre_reg;
  logic [7:0] cnt_reg;
  logic pre_last;

  assign pre_last = speed_high ? (pre_reg[3:0] == 4'hF)
                               : (pre_reg == ucb_pkg::PRESCALE_LOW_LAST);

  // ==========================================================
  // Prescaler and reloading 8-bit timer
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_reg <= 6'h00;
      cnt_reg <= ucb_pkg::RST_DIVISOR;
      tick <= 1'b0;
    end
    else if (clk_en)
    begin
      if (clear)
      begin
        pre_reg <= 6'h00; // [R21]
        cnt_reg <= divisor;
        tick <= 1'b0;
      end
      else
      begin
        pre_reg <= pre_last ? 6'h00 : pre_reg + 6'h01; // [R5]
        tick <= 1'b0;
        if (pre_last)
        begin
          if (cnt_reg == 8'h00)
          begin
            cnt_reg <= divisor; // [R6] [R21]
            tick <= 1'b1;
          end
          else
            cnt_reg <= cnt_reg - 8'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### design/ucb_wake_detect.sv
// Purpose: Falling-edge wake request on the shared line
// Assumes: unit_clk_on reflects the unit clock gate
// Notes: Request holds until the unit clock is switched back on
`timescale 1ns/10ps
`default_nettype none
module ucb_wake_detect
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Control
  input wire logic wake_en,
  input wire logic unit_clk_on,
  input wire logic line_in,
  // Request
  output logic wake_req
);

  logic line_d_reg;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      line_d_reg <= 1'b1;
      wake_req <= 1'b0;
    end
    else if (clk_en)
    begin
      line_d_reg <= line_in;
      if (unit_clk_on)
        wake_req <= 1'b0; // [R10] [R11]
      else if (wake_en && line_d_reg && !line_in)
        wake_req <= 1'b1; // [R9]
    end
  end

endmodule
`default_nettype wire

// ### design/ucb_control.sv
// Purpose: Serial port control, data buffer and pin steering
// Assumes: Shift engine outside; registers via plain strobe port
// Notes: Outputs registered; read data one cycle late
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// [R1] Transmit enable low aborts, empties transmit buffer, floats transmit pin.
// [R2] Transmitter runs and drives its pin only with both enables set.
// [R3] Receive enable low aborts reception, resets receiver, floats shared line; the block drives it in single-line with transmit enabled.
// [R4] Receiver runs on the shared line only with both enables set.
// [R5] Bit rate is clock over 64(N+1) low speed, 16(N+1) high.
// [R6] Timing comes from a free-running 8-bit timer, N from 0 to 255.
// [R7] Address detect: word with address bit one is kept and interrupts.
// [R8] Address detect: word with address bit zero is dropped silently.
// [R9] Wake enabled and unit clock stopped: falling edge raises wake request.
// [R10] No wake request while clock runs, none with wake disabled.
// [R11] Software turns the unit clock back on after a wake.
// [R12] Receive interrupt enable routes overrun and ready flags to request.
// [R13] Idle interrupt enable routes the transmit idle flag to request.
// [R14] Empty interrupt enable routes the transmit empty flag to request.
// [R15] Single-line off: shared line only receives; on: follows enables.
// [R16] Single-line with both enables high: shared line only receives.
// [R17] Single-line register: bits 7 to 1 read zero, bit 0 resets zero.
// [R18] One data register: writes transmit, reads return received character.
// [R19] Master enable low disables all and floats both pins.
// [R20] Nine-bit format stores received ninth bit, sends stored ninth bit.
// [R21] Bit timer reloads N at terminal count, reset while disabled.
// [R22] Request is OR of enabled sources, held until flags serviced.
module ucb_control
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  // Shift engine, transmit side
  output logic eng_tx_run,
  output logic eng_tx_valid,
  output logic [7:0] eng_tx_data,
  output logic eng_tx_ninth,
  input wire logic eng_tx_taken,
  input wire logic eng_tx_done,
  input wire logic eng_tx_bit,
  // Shift engine, receive side
  output logic eng_rx_run,
  output logic eng_rx_line,
  input wire logic eng_rx_valid,
  input wire logic [7:0] eng_rx_data,
  input wire logic eng_rx_ninth,
  // Shared setup to engine
  output logic eng_nine_bit,
  output logic eng_baud_tick,
  // Pins
  output logic tx_pin_out,
  output logic tx_pin_oe,
  input wire logic shared_line_in,
  output logic shared_line_out,
  output logic shared_line_oe,
  // Unit clock gate and requests
  input wire logic unit_clk_on,
  output logic irq_req,
  output logic wake_req
);

  // ==========================================================
  // Register state
  logic port_master_enable;
  logic word_length_select;
  logic tx_ninth_bit;
  logic rx_ninth_bit;
  logic [7:0] control_two_reg;
  logic single_line_select;
  logic [7:0] divisor_bits;
  logic [7:0] rx_data_reg;
  logic tx_full_reg;
  logic overrun_flag;
  logic rx_ready_flag;
  logic tx_idle_flag;
  logic status_seen_reg;
  logic baud_tick;
  logic wake_pend;

  logic tx_enable_ctl;
  logic rx_enable_ctl;
  logic rate_speed_select;
  logic address_detect_enable;
  logic wake_enable;
  logic receive_irq_enable;
  logic tx_idle_irq_enable;
  logic tx_empty_irq_enable;
  logic tx_active;
  logic rx_active;
  logic tx_empty_flag;
  logic rx_addr_bit;
  logic rx_keep;
  logic wr_data_buf;
  logic rd_data_buf;
  logic rd_status;
  logic irq_next;
  logic shared_tx;

  assign tx_enable_ctl = control_two_reg[ucb_pkg::BIT_TX_EN];
  assign rx_enable_ctl = control_two_reg[ucb_pkg::BIT_RX_EN];
  assign rate_speed_select = control_two_reg[ucb_pkg::BIT_SPEED];
  assign address_detect_enable = control_two_reg[ucb_pkg::BIT_ADDR_DET];
  assign wake_enable = control_two_reg[ucb_pkg::BIT_WAKE_EN];
  assign receive_irq_enable = control_two_reg[ucb_pkg::BIT_RX_IE];
  assign tx_idle_irq_enable = control_two_reg[ucb_pkg::BIT_IDLE_IE];
  assign tx_empty_irq_enable = control_two_reg[ucb_pkg::BIT_EMPTY_IE];

  assign tx_active = port_master_enable && tx_enable_ctl; // [R2] [R19]
  assign rx_active = port_master_enable && rx_enable_ctl; // [R4] [R19]
  assign tx_empty_flag = !tx_full_reg;

  // Shared line drives only for a lone transmitter
  assign shared_tx = single_line_select && tx_active
                     && !rx_enable_ctl; // [R15] [R16]

  // Address bit: ninth bit in 9-bit format, else data bit 7
  assign rx_addr_bit = word_length_select ? eng_rx_ninth
                                          : eng_rx_data[7]; // [R7]
  assign rx_keep = !address_detect_enable || rx_addr_bit; // [R7] [R8]

  assign wr_data_buf = wr_en && (addr == ucb_pkg::OFS_DATA_BUFFER);
  assign rd_data_buf = rd_en && (addr == ucb_pkg::OFS_DATA_BUFFER);
  assign rd_status = rd_en && (addr == ucb_pkg::OFS_STATUS);

  // ==========================================================
  // Control one: master enable, word length, transmit ninth bit
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      port_master_enable <= ucb_pkg::RST_CONTROL_ONE[ucb_pkg::BIT_MASTER_EN];
      word_length_select <= ucb_pkg::RST_CONTROL_ONE[ucb_pkg::BIT_WORD_LEN];
      tx_ninth_bit <= ucb_pkg::RST_CONTROL_ONE[ucb_pkg::BIT_TX_NINTH];
    end
    else if (clk_en && wr_en && addr == ucb_pkg::OFS_CONTROL_ONE)
    begin
      port_master_enable <= wr_data[ucb_pkg::BIT_MASTER_EN];
      word_length_select <= wr_data[ucb_pkg::BIT_WORD_LEN];
      tx_ninth_bit <= wr_data[ucb_pkg::BIT_TX_NINTH]; // [R20]
    end
  end

  // ==========================================================
  // Control two: direction enables cleared while unit disabled
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      control_two_reg <= ucb_pkg::RST_CONTROL_TWO;
    else if (clk_en)
    begin
      if (wr_en && addr == ucb_pkg::OFS_CONTROL_TWO)
        control_two_reg <= wr_data;
      if (!port_master_enable)
      begin
        control_two_reg[ucb_pkg::BIT_TX_EN] <= 1'b0; // [R19]
        control_two_reg[ucb_pkg::BIT_RX_EN] <= 1'b0; // [R19]
      end
    end
  end

  // ==========================================================
  // Single line and divisor
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      single_line_select <= ucb_pkg::RST_SINGLE_LINE[0]; // [R17]
      divisor_bits <= ucb_pkg::RST_DIVISOR;
    end
    else if (clk_en && wr_en)
    begin
      if (addr == ucb_pkg::OFS_SINGLE_LINE)
        single_line_select <= wr_data[ucb_pkg::BIT_SINGLE_LINE]; // [R17]
      if (addr == ucb_pkg::OFS_DIVISOR)
        divisor_bits <= wr_data; // [R6]
    end
  end

  // ==========================================================
  // Transmit buffer and handover to the shift engine
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_full_reg <= 1'b0;
      eng_tx_data <= ucb_pkg::RST_DATA;
      eng_tx_ninth <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!tx_active)
        tx_full_reg <= 1'b0; // [R1] [R19]
      else if (wr_data_buf && tx_empty_flag)
      begin
        tx_full_reg <= 1'b1; // [R18]
        eng_tx_data <= wr_data; // [R18]
        eng_tx_ninth <= tx_ninth_bit; // [R20]
      end
      else if (eng_tx_taken)
        tx_full_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Status read arms the flag-clearing data access
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      status_seen_reg <= 1'b0;
    else if (clk_en)
    begin
      if (rd_status)
        status_seen_reg <= 1'b1;
      else if (wr_data_buf || rd_data_buf)
        status_seen_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Transmit idle flag: set on frame end, set wins over clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tx_idle_flag <= 1'b1;
    else if (clk_en)
    begin
      if (!tx_active)
        tx_idle_flag <= 1'b1; // [R1] [R19]
      else if (eng_tx_done && !tx_full_reg)
        tx_idle_flag <= 1'b1;
      else if (wr_data_buf && status_seen_reg && tx_empty_flag)
        tx_idle_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Receive data, ninth bit, ready and overrun
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_data_reg <= ucb_pkg::RST_DATA;
      rx_ninth_bit <= 1'b0;
      rx_ready_flag <= 1'b0;
      overrun_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!rx_active)
      begin
        rx_ready_flag <= 1'b0; // [R3] [R19]
        overrun_flag <= 1'b0; // [R3] [R19]
      end
      else if (eng_rx_valid && rx_keep)
      begin
        if (rx_ready_flag && !rd_data_buf)
          overrun_flag <= 1'b1;
        else
        begin
          rx_data_reg <= eng_rx_data; // [R18]
          rx_ninth_bit <= eng_rx_ninth; // [R20]
          rx_ready_flag <= 1'b1;
          if (rd_data_buf && status_seen_reg)
            overrun_flag <= 1'b0;
        end
      end
      else if (rd_data_buf)
      begin
        rx_ready_flag <= 1'b0;
        if (status_seen_reg)
          overrun_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Bit-rate generator and pin wake detector
  ucb_baud_gen u_baud
  (
    .clk(clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .clear(!port_master_enable), // [R21]
    .speed_high(rate_speed_select), // [R5]
    .divisor(divisor_bits),
    .tick(baud_tick)
  );

  ucb_wake_detect u_wake
  (
    .clk(clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .wake_en(wake_enable), // [R9] [R10]
    .unit_clk_on(unit_clk_on),
    .line_in(shared_line_in),
    .wake_req(wake_pend)
  );

  // ==========================================================
  // Interrupt request: OR of enabled sources, held by the flags
  always_comb
  begin
    irq_next = 1'b0;
    if (receive_irq_enable && (overrun_flag || rx_ready_flag))
      irq_next = 1'b1; // [R12] [R7]
    if (tx_idle_irq_enable && tx_idle_flag)
      irq_next = 1'b1; // [R13]
    if (tx_empty_irq_enable && tx_empty_flag && tx_active)
      irq_next = 1'b1; // [R14]
    if (wake_pend)
      irq_next = 1'b1; // [R9]
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_req <= 1'b0;
      wake_req <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_req <= irq_next; // [R22]
      wake_req <= wake_pend;
    end
  end

  // ==========================================================
  // Engine controls and pin steering
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      eng_tx_run <= 1'b0;
      eng_rx_run <= 1'b0;
      eng_tx_valid <= 1'b0;
      eng_nine_bit <= 1'b0;
      eng_baud_tick <= 1'b0;
      eng_rx_line <= 1'b1;
      tx_pin_out <= 1'b1;
      tx_pin_oe <= 1'b0;
      shared_line_out <= 1'b1;
      shared_line_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      eng_tx_run <= tx_active; // [R1] [R2]
      eng_rx_run <= rx_active && !shared_tx; // [R3] [R4] [R16]
      eng_tx_valid <= tx_full_reg && tx_active && !eng_tx_taken;
      eng_nine_bit <= word_length_select; // [R20]
      eng_baud_tick <= baud_tick; // [R5]
      eng_rx_line <= shared_line_in;
      tx_pin_out <= tx_active ? eng_tx_bit : 1'b1;
      tx_pin_oe <= tx_active; // [R1] [R2] [R19]
      shared_line_out <= shared_tx ? eng_tx_bit : 1'b1;
      shared_line_oe <= shared_tx; // [R3] [R15] [R16] [R19]
    end
  end

  // ==========================================================
  // Read port: data one cycle after the read strobe
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rd_data <= 8'h00;
    else if (clk_en)
    begin
      rd_data <= 8'h00;
      if (rd_en)
      begin
        unique case (addr)
          ucb_pkg::OFS_CONTROL_ONE:
            rd_data <= {port_master_enable, word_length_select, 4'h0,
                        rx_ninth_bit, 1'b0};
          ucb_pkg::OFS_CONTROL_TWO:
            rd_data <= control_two_reg;
          ucb_pkg::OFS_SINGLE_LINE:
            rd_data <= {7'h00, single_line_select}; // [R17]
          ucb_pkg::OFS_DATA_BUFFER:
            rd_data <= rx_data_reg; // [R18]
          ucb_pkg::OFS_DIVISOR:
            rd_data <= divisor_bits;
          ucb_pkg::OFS_STATUS:
            rd_data <= {2'h0, overrun_flag, wake_pend, 1'b0,
                        rx_ready_flag, tx_idle_flag, tx_empty_flag};
          default:
            rd_data <= 8'h00;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ### bench/ucb_control_assertions.sv
// Purpose: Port checks of the serial control block
// Assumes: Single clock domain, reset active low
// Notes: Bound to ucb_control below
`timescale 1ns/10ps
`default_nettype none
module ucb_control_checker
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic rd_en,
  input wire logic [2:0] addr,
  input wire logic [7:0] rd_data,
  // Engine and pins
  input wire logic eng_tx_run,
  input wire logic eng_tx_valid,
  input wire logic eng_tx_taken,
  input wire logic [7:0] eng_tx_data,
  input wire logic eng_rx_run,
  input wire logic eng_rx_line,
  input wire logic eng_baud_tick,
  input wire logic tx_pin_oe,
  input wire logic shared_line_in,
  input wire logic shared_line_oe,
  input wire logic unit_clk_on,
  input wire logic wake_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Register port
  a_rd_idle_zero:
    assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("rd_data not zero");
  a_line_upper_zero:
    assert property (rd_en && addr == ucb_pkg::OFS_SINGLE_LINE
      |=> rd_data[7:1] == 7'h00) else $error("line upper bits set");
  // ==========================================================
  // Transmit side
  a_tx_pin_float:
    assert property (!eng_tx_run && !$past(eng_tx_run) |-> !tx_pin_oe)
    else $error("tx pin driven while off");
  a_buf_abort:
    assert property (!eng_tx_run |=> !eng_tx_valid)
    else $error("tx buffer kept while off");
  a_tx_pop:
    assert property (eng_tx_valid && eng_tx_taken |=> !eng_tx_valid)
    else $error("tx valid kept");
  a_tx_data_hold:
    assert property (eng_tx_valid && !eng_tx_taken ##1 eng_tx_valid
      |-> $stable(eng_tx_data)) else $error("tx data moved");
  // ==========================================================
  // Receive side and timing
  a_rx_only_line:
    assert property (eng_rx_run && $past(eng_rx_run) |-> !shared_line_oe)
    else $error("shared line driven in rx");
  a_rx_line_delay:
    assert property (eng_rx_line == $past(shared_line_in))
    else $error("rx line not delayed");
  a_tick_single:
    assert property (eng_baud_tick |=> !eng_baud_tick)
    else $error("tick too long");
  // ==========================================================
  // Wake request
  a_wake_hold:
    assert property (wake_req && !unit_clk_on |=> wake_req)
    else $error("wake dropped");
  a_wake_clk_on:
    assert property (unit_clk_on [*3] |-> !wake_req)
    else $error("wake with clock on");
endmodule
bind ucb_control ucb_control_checker chk (.*);
`default_nettype wire

// ### bench/ucb_engine_model.sv
// Purpose: Shift engine and remote side stand-in
// Assumes: One-cycle pulses after rising edges
// Notes: slow stretches take delay
`timescale 1ns/10ps
`default_nettype none
module ucb_engine_model
(
  // Clock and pacing
  input wire logic clk,
  input wire logic slow,
  // From control block
  input wire logic eng_tx_valid,
  // To control block
  output logic eng_tx_taken,
  output logic eng_tx_done,
  output logic eng_tx_bit,
  output logic eng_rx_valid,
  output logic [7:0] eng_rx_data,
  output logic eng_rx_ninth
);
  initial
  begin
    eng_tx_taken = 1'b0;
    eng_tx_done = 1'b0;
    eng_tx_bit = 1'b1;
    eng_rx_valid = 1'b0;
    eng_rx_data = 8'h00;
    eng_rx_ninth = 1'b0;
  end
  // Take a queued char, then finish its frame
  initial
  forever
  begin
    @(posedge clk);
    if (eng_tx_valid === 1'b1)
    begin
      repeat (slow ? 20 : 1) @(posedge clk);
      eng_tx_taken <= 1'b1;
      @(posedge clk);
      eng_tx_taken <= 1'b0;
      repeat (4) @(posedge clk);
      eng_tx_done <= 1'b1;
      @(posedge clk);
      eng_tx_done <= 1'b0;
    end
  end
  // One received word, then inverted stale data
  task send_word(input logic [7:0] d, input logic n);
    @(posedge clk);
    eng_rx_valid <= 1'b1;
    eng_rx_data <= d;
    eng_rx_ninth <= n;
    @(posedge clk);
    eng_rx_valid <= 1'b0;
    eng_rx_data <= ~d;
    eng_rx_ninth <= ~n;
  endtask
endmodule
`default_nettype wire

// ### bench/ucb_control_tb_top.sv
// Purpose: Directed register test of the serial control block
// Assumes: 40 MHz clock, clk_en high
// Notes: Prints mismatches and verdict only
`timescale 1ns/10ps
`default_nettype none
module ucb_control_tb_top;
  logic clk, rstn, clk_en, wr_en, rd_en, slow, shared_line_in, unit_clk_on;
  logic [2:0] addr;
  logic [7:0] wr_data, rd_data, eng_tx_data, eng_rx_data, v;
  logic eng_tx_run, eng_tx_valid, eng_tx_ninth, eng_tx_taken, eng_tx_done;
  logic eng_tx_bit, eng_rx_run, eng_rx_line, eng_rx_valid, eng_rx_ninth;
  logic eng_nine_bit, eng_baud_tick, tx_pin_out, tx_pin_oe, irq_req;
  logic shared_line_out, shared_line_oe, wake_req;
  int num_errors, num_checks, n;
  localparam logic [2:0] C1 = ucb_pkg::OFS_CONTROL_ONE;
  localparam logic [2:0] C2 = ucb_pkg::OFS_CONTROL_TWO;
  localparam logic [2:0] DB = ucb_pkg::OFS_DATA_BUFFER;
  localparam logic [2:0] SL = ucb_pkg::OFS_SINGLE_LINE;
  logic [7:0] a_c1[4] = '{8'h80, 8'h80, 8'hC0, 8'hC0};
  logic [7:0] a_d[4] = '{8'h15, 8'h95, 8'h80, 8'h00};
  logic a_n[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  logic [7:0] a_k[4] = '{8'h00, 8'h01, 8'h00, 8'h01};
  logic [7:0] ie_c2[4] = '{8'h81, 8'h80, 8'h82, 8'h80};
  logic [7:0] ie_q[4] = '{8'h01, 8'h00, 8'h01, 8'h00};
  ucb_control dut (.clk, .rstn, .clk_en, .addr, .wr_data, .wr_en, .rd_en,
    .rd_data, .eng_tx_run, .eng_tx_valid, .eng_tx_data, .eng_tx_ninth,
    .eng_tx_taken, .eng_tx_done, .eng_tx_bit, .eng_rx_run, .eng_rx_line,
    .eng_rx_valid, .eng_rx_data, .eng_rx_ninth, .eng_nine_bit,
    .eng_baud_tick, .tx_pin_out, .tx_pin_oe, .shared_line_in,
    .shared_line_out, .shared_line_oe, .unit_clk_on, .irq_req, .wake_req);
  ucb_engine_model eng (.clk, .slow, .eng_tx_valid, .eng_tx_taken,
    .eng_tx_done, .eng_tx_bit, .eng_rx_valid, .eng_rx_data, .eng_rx_ninth);
  // ==========================================================
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  task wrap_up;
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chki(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask
  task settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task wait_tx(input logic lvl);
    n = 0;
    while (eng_tx_valid !== lvl && n < 100)
    begin
      settle(1);
      n++;
    end
    if (n >= 100)
    begin
      chki("tx valid wait", 16'h0000, n[15:0]);
      wrap_up;
    end
  endtask
  task wait_tick(output int c);
    c = 0;
    do
    begin
      settle(1);
      c++;
    end
    while (eng_baud_tick !== 1'b1 && c < 20000);
    if (c >= 20000)
    begin
      chki("tick wait", 16'h0000, c[15:0]);
      wrap_up;
    end
  endtask
  task period(input int e);
    repeat (3) wait_tick(n);
    chki("tick period", e[15:0], n[15:0]);
  endtask
  // ==========================================================
  // Sequence
  initial
  begin
    {rstn, wr_en, rd_en, slow, addr, wr_data} = '0;
    {clk_en, shared_line_in, unit_clk_on} = 3'b111;
    num_errors = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(C2, v);
    chk8("control two reset", 8'h00, v);
    rd(ucb_pkg::OFS_DIVISOR, v);
    chk8("divisor reset", 8'h00, v);
    rd(SL, v);
    chk8("single line reset", 8'h00, v);
    wr(SL, 8'hFF);
    rd(SL, v);
    chk8("single line", 8'h01, v);
    wr(SL, 8'h00);
    wr(C1, 8'h80);
    wr(C2, 8'hC0);
    settle(2);
    chk8("tx pin oe", 8'h01, {7'h00, tx_pin_oe});
    chk8("rx run", 8'h01, {7'h00, eng_rx_run});
    chk8("shared oe", 8'h00, {7'h00, shared_line_oe});
    @(posedge clk) slow <= 1'b1;
    wr(DB, 8'h5A);
    wait_tx(1'b1);
    wr(DB, 8'h33);
    settle(1);
    chk8("tx data", 8'h5A, eng_tx_data);
    wait_tx(1'b0);
    wr(C1, 8'hC1);
    wr(DB, 8'hC3);
    wait_tx(1'b1);
    chk8("tx data", 8'hC3, eng_tx_data);
    chk8("tx ninth", 8'h01, {7'h00, eng_tx_ninth});
    chk8("nine bit", 8'h01, {7'h00, eng_nine_bit});
    @(posedge clk) slow <= 1'b0;
    wait_tx(1'b0);
    wr(C2, 8'hC4);
    eng.send_word(8'hA5, 1'b0);
    settle(3);
    chk8("irq", 8'h01, {7'h00, irq_req});
    rd(ucb_pkg::OFS_STATUS, v);
    rd(DB, v);
    chk8("rx data", 8'hA5, v);
    settle(2);
    chk8("irq", 8'h00, {7'h00, irq_req});
    wr(C2, 8'hD4);
    for (int i = 0; i < 4; i++)
    begin
      wr(C1, a_c1[i]);
      eng.send_word(a_d[i], a_n[i]);
      settle(2);
      rd(ucb_pkg::OFS_STATUS, v);
      chk8("rx ready", a_k[i], {7'h00, v[2]});
      if (a_k[i] == 8'h01)
      begin
        rd(C1, v);
        chk8("rx ninth", {7'h00, a_n[i]}, {7'h00, v[1]});
        rd(DB, v);
        chk8("rx data", a_d[i], v);
      end
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(C2, ie_c2[i]);
      settle(3);
      chk8("irq", ie_q[i], {7'h00, irq_req});
    end
    wr(C2, 8'hC0);
    @(posedge clk) slow <= 1'b1;
    wr(DB, 8'h11);
    wait_tx(1'b1);
    wr(C2, 8'h40);
    settle(3);
    chk8("tx valid", 8'h00, {7'h00, eng_tx_valid});
    chk8("tx pin oe", 8'h00, {7'h00, tx_pin_oe});
    chk8("rx run", 8'h01, {7'h00, eng_rx_run});
    wr(C2, 8'h80);
    settle(3);
    chk8("rx run", 8'h00, {7'h00, eng_rx_run});
    wr(SL, 8'h01);
    settle(3);
    chk8("shared oe", 8'h01, {7'h00, shared_line_oe});
    @(posedge clk) slow <= 1'b0;
    wr(C2, 8'hC0);
    wr(C1, 8'h00);
    settle(3);
    chk8("tx pin oe", 8'h00, {7'h00, tx_pin_oe});
    chk8("shared oe", 8'h00, {7'h00, shared_line_oe});
    rd(C2, v);
    chk8("control two", 8'h00, v);
    wr(C1, 8'h80);
    wr(C2, 8'h20);
    wr(ucb_pkg::OFS_DIVISOR, 8'hFF);
    period(4096);
    wr(C2, 8'h00);
    wr(ucb_pkg::OFS_DIVISOR, 8'h00);
    period(64);
    wr(C2, 8'h08);
    @(posedge clk) unit_clk_on <= 1'b0;
    @(posedge clk) shared_line_in <= 1'b0;
    settle(3);
    chk8("wake", 8'h01, {7'h00, wake_req});
    @(posedge clk) unit_clk_on <= 1'b1;
    settle(3);
    chk8("wake", 8'h00, {7'h00, wake_req});
    @(posedge clk) shared_line_in <= 1'b1;
    wr(C2, 8'h00);
    @(posedge clk) unit_clk_on <= 1'b0;
    @(posedge clk) shared_line_in <= 1'b0;
    settle(3);
    chk8("wake", 8'h00, {7'h00, wake_req});
    wrap_up;
  end
endmodule
`default_nettype wire
